// ---- core/backdoor_key_check.sv ----
module backdoor_key_check #(
	parameter int NBYTES = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic finish,
	input wire logic byte_we,
	input wire logic [$clog2(NBYTES)-1:0] byte_idx,
	input wire logic [7:0] byte_data,
	input wire logic [NBYTES*8-1:0] stored_key,
	output logic match
);
	localparam int CW = $clog2(NBYTES) + 1;
	localparam logic [CW-1:0] FULL = CW'(NBYTES);

	logic [NBYTES*8-1:0] entry_ff;
	logic [CW-1:0] next_ff;
	logic order_ok_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_ff <= '0;
		end else if (byte_we) begin
			entry_ff[byte_idx*8 +: 8] <= byte_data;
		end
	end

	// out-of-order or surplus bytes spoil the session
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_ff <= '0;
			order_ok_ff <= 1'b0;
		end else if (start) begin
			next_ff <= '0;
			order_ok_ff <= 1'b1;
		end else if (byte_we) begin
			if (next_ff == FULL || {1'b0, byte_idx} != next_ff) begin
				order_ok_ff <= 1'b0;
			end
			if (next_ff != FULL) begin
				next_ff <= next_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match <= 1'b0;
		end else begin
			match <= finish && order_ok_ff && next_ff == FULL && entry_ff == stored_key;
		end
	end
endmodule // backdoor_key_check

// ---- core/flash_clock_and_security_options.sv ----
module flash_clock_and_security_options #(
	parameter int OPW = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] nonvolatile_options_byte,
	input wire logic [63:0] stored_backdoor_key,
	input wire logic fw_secure_source,
	input wire logic access_from_unsecured,
	input wire logic blank_check_erased,
	input wire logic op_start,
	input wire logic [OPW-1:0] op_pulse_count,
	output logic erase_program_enable,
	output logic internal_flash_clock,
	output logic op_busy,
	output logic op_done,
	output logic cmd_launch,
	output logic [2:0] cmd_addr_idx,
	output logic [7:0] cmd_data,
	output logic secure_state,
	output logic mem_access_blocked,
	output logic vector_redirect_en
);
	// =========================================
	// bus decode
	logic setup_ph;
	logic wr_acc;
	logic hit_ratio;
	logic hit_opts;
	logic hit_cnfg;
	logic hit_stat;
	logic hit_key;
	logic mapped;
	logic lane0;
	logic [2:0] key_idx;

	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign lane0 = pstrb[0];
	assign key_idx = paddr[4:2];
	assign hit_key = (paddr & flash_opt_pkg::KEY_MASK) == flash_opt_pkg::KEY_BASE;
	always_comb begin
		hit_ratio = 1'b0;
		hit_opts = 1'b0;
		hit_cnfg = 1'b0;
		hit_stat = 1'b0;
		if (paddr[7:2] == flash_opt_pkg::RATIO_OFFS[7:2]) begin
			hit_ratio = 1'b1;
		end else if (paddr[7:2] == flash_opt_pkg::OPTS_OFFS[7:2]) begin
			hit_opts = 1'b1;
		end else if (paddr[7:2] == flash_opt_pkg::CNFG_OFFS[7:2]) begin
			hit_cnfg = 1'b1;
		end else if (paddr[7:2] == flash_opt_pkg::STAT_OFFS[7:2]) begin
			hit_stat = 1'b1;
		end
	end
	assign mapped = hit_ratio || hit_opts || hit_cnfg || hit_stat || hit_key;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// =========================================
	// clock ratio register
	logic ratio_loaded_ff;
	logic [6:0] ratio_ff;
	logic ratio_wr;

	assign ratio_wr = wr_acc && hit_ratio && lane0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_loaded_ff <= 1'b0;
			ratio_ff <= flash_opt_pkg::RATIO_RESET;
		end else if (ratio_wr && !ratio_loaded_ff) begin
			ratio_loaded_ff <= 1'b1;
			ratio_ff <= pwdata[6:0];
		end
	end
	assign erase_program_enable = ratio_loaded_ff;

	// divider runs once loaded so a half-set ratio never ticks
	flash_tick_divider #(
		.DIV_W(6)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(ratio_loaded_ff),
		.prescale_by_eight(ratio_ff[flash_opt_pkg::PRE8_BIT]),
		.ratio(ratio_ff[5:0]),
		.tick(internal_flash_clock)
	);

	// software-visible check that the chosen rate gives a legal pulse
	logic [10:0] div_total;
	logic [10:0] div_plain;
	logic rate_ok;
	assign div_plain = {5'h00, ratio_ff[5:0]} + 11'h001;
	assign div_total = ratio_ff[flash_opt_pkg::PRE8_BIT] ? (div_plain << 3) : div_plain;
	assign rate_ok = div_total >= 11'(flash_opt_pkg::PULSE_MIN_CYC) &&
		div_total <= 11'(flash_opt_pkg::PULSE_MAX_CYC);

	// =========================================
	// options register
	logic [7:0] opts_ff;
	logic opts_loaded_ff;
	logic key_hit;
	logic unlock;

	assign unlock = key_hit || blank_check_erased;

	// nonvolatile byte taken on the first edge after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opts_ff <= flash_opt_pkg::OPTS_RESET;
			opts_loaded_ff <= 1'b0;
		end else if (!opts_loaded_ff) begin
			opts_ff <= nonvolatile_options_byte;
			opts_loaded_ff <= 1'b1;
		end else if (unlock) begin
			opts_ff[1:0] <= flash_opt_pkg::SEC_UNSECURED;
		end
	end

	assign secure_state = opts_ff[1:0] != flash_opt_pkg::SEC_UNSECURED;
	assign mem_access_blocked = secure_state && access_from_unsecured;
	assign vector_redirect_en = !opts_ff[flash_opt_pkg::NORED_BIT];

	// =========================================
	// configuration and key window
	logic kwa_ff;
	logic kwa_wr;
	logic key_wr;
	logic key_byte_we;
	logic key_start;
	logic key_finish;
	logic key_match;

	assign kwa_wr = wr_acc && hit_cnfg && lane0;
	assign key_wr = wr_acc && hit_key && lane0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kwa_ff <= 1'b0;
		end else if (kwa_wr) begin
			kwa_ff <= pwdata[flash_opt_pkg::KWA_BIT];
		end
	end
	assign key_start = kwa_wr && !kwa_ff && pwdata[flash_opt_pkg::KWA_BIT];
	assign key_finish = kwa_wr && kwa_ff && !pwdata[flash_opt_pkg::KWA_BIT];
	// debug-originated key bytes are dropped silently
	assign key_byte_we = key_wr && kwa_ff && fw_secure_source;

	backdoor_key_check #(
		.NBYTES(flash_opt_pkg::KEY_BYTES)
	) u_key (
		.pclk(pclk),
		.presetn(presetn),
		.start(key_start),
		.finish(key_finish),
		.byte_we(key_byte_we),
		.byte_idx(key_idx),
		.byte_data(pwdata[7:0]),
		.stored_key(stored_backdoor_key),
		.match(key_match)
	);
	assign key_hit = key_match && opts_ff[flash_opt_pkg::BACKDOOR_KEY_ENABLE_BIT];

	// =========================================
	// command launch and access error
	logic launch_try;
	logic op_try;
	logic err_ff;
	logic err_set;
	logic err_clr;

	assign launch_try = key_wr && !kwa_ff;
	assign op_try = op_start && !op_busy;
	assign err_set = (launch_try || op_try) && !ratio_loaded_ff;
	assign err_clr = wr_acc && hit_stat && lane0 && pwdata[flash_opt_pkg::ERR_BIT];

	// set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_ff <= 1'b0;
		end else if (err_set) begin
			err_ff <= 1'b1;
		end else if (err_clr) begin
			err_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_launch <= 1'b0;
			cmd_addr_idx <= '0;
			cmd_data <= '0;
		end else begin
			cmd_launch <= launch_try && ratio_loaded_ff;
			if (launch_try && ratio_loaded_ff) begin
				cmd_addr_idx <= key_idx;
				cmd_data <= pwdata[7:0];
			end
		end
	end

	// =========================================
	// operation timer in flash clock ticks, first counted pulse may be partial
	logic [OPW-1:0] op_cnt_ff;
	logic op_busy_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_busy_ff <= 1'b0;
			op_cnt_ff <= '0;
			op_done <= 1'b0;
		end else begin
			op_done <= 1'b0;
			if (op_try && ratio_loaded_ff && op_pulse_count != '0) begin
				op_busy_ff <= 1'b1;
				op_cnt_ff <= op_pulse_count;
			end else if (op_busy_ff && internal_flash_clock) begin
				op_cnt_ff <= op_cnt_ff - 1'b1;
				if (op_cnt_ff == {{(OPW-1){1'b0}}, 1'b1}) begin
					op_busy_ff <= 1'b0;
					op_done <= 1'b1;
				end
			end
		end
	end
	assign op_busy = op_busy_ff;

	// =========================================
	// read data
	logic [7:0] nxt_rd;

	always_comb begin
		nxt_rd = 8'h00;
		if (hit_ratio) begin
			nxt_rd = {ratio_loaded_ff, ratio_ff};
		end else if (hit_opts) begin
			nxt_rd = {opts_ff[7:6], 4'h0, opts_ff[1:0]};
		end else if (hit_cnfg) begin
			nxt_rd[flash_opt_pkg::KWA_BIT] = kwa_ff;
		end else if (hit_stat) begin
			nxt_rd[flash_opt_pkg::BUSY_BIT] = op_busy_ff;
			nxt_rd[flash_opt_pkg::RATE_OK_BIT] = rate_ok;
			nxt_rd[flash_opt_pkg::ERR_BIT] = err_ff;
			nxt_rd[flash_opt_pkg::UNSEC_BIT] = !secure_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_ph && !pwrite) begin
			prdata <= {24'h000000, nxt_rd};
		end
	end

	// =========================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ratio_write_once_a: assert property (
		ratio_loaded_ff && ratio_wr |=> $stable(ratio_ff))
		else $error("ratio field changed after first write");
	loaded_on_write_a: assert property (
		ratio_wr |=> ratio_loaded_ff && erase_program_enable)
		else $error("loaded flag not set by ratio write");
	launch_gated_a: assert property (
		cmd_launch |-> $past(ratio_loaded_ff))
		else $error("command launched before ratio loaded");
	early_error_a: assert property (
		launch_try && !ratio_loaded_ff |=> err_ff && !cmd_launch)
		else $error("early command not refused with error");
	tick_rate_a: assert property (
		internal_flash_clock && ratio_ff[5:0] == 6'h01 && !ratio_ff[6]
		|=> !internal_flash_clock ##1 internal_flash_clock)
		else $error("flash tick period wrong for ratio one");
	unlock_cause_a: assert property (
		opts_loaded_ff && $past(opts_loaded_ff) && $rose(!secure_state) |->
		$past(blank_check_erased) || $past(key_match && opts_ff[7]))
		else $error("unsecured without valid cause");
	key_source_a: assert property (
		key_wr && !fw_secure_source |-> !key_byte_we)
		else $error("debug key byte accepted");
	opts_frozen_a: assert property (
		opts_loaded_ff |=> $stable(opts_ff[7:2]))
		else $error("options changed without reset");
	secure_decode_a: assert property (
		mem_access_blocked |-> access_from_unsecured && opts_ff[1:0] != 2'h2)
		else $error("access blocked while unsecured");
	op_timed_a: assert property (
		op_done |-> $past(internal_flash_clock) && !op_busy)
		else $error("operation ended off a flash tick");
	loaded_sticky_a: assert property (
		ratio_loaded_ff |=> ratio_loaded_ff)
		else $error("loaded flag dropped without reset");
	busy_gate_a: assert property (
		!ratio_loaded_ff |-> !op_busy && !erase_program_enable)
		else $error("operation running before ratio loaded");
	cmd_quiet_a: assert property (
		!ratio_loaded_ff |=> !cmd_launch)
		else $error("command launched while ratio unloaded");
	early_op_a: assert property (
		op_try && !ratio_loaded_ff |=> err_ff && !op_busy)
		else $error("early operation not refused with error");
	err_keep_a: assert property (
		err_ff && !err_clr |=> err_ff)
		else $error("access error dropped without clear");
	op_run_a: assert property (
		op_busy_ff && op_cnt_ff > OPW'(1) |=> op_busy_ff)
		else $error("operation ended before its pulse count");
	key_window_a: assert property (
		key_byte_we |-> kwa_ff && hit_key)
		else $error("key byte taken outside key access");
	cmd_echo_a: assert property (
		launch_try && ratio_loaded_ff |=>
		cmd_launch && cmd_addr_idx == $past(key_idx) && cmd_data == $past(pwdata[7:0]))
		else $error("command index or data not passed on");
	key_off_a: assert property (
		opts_loaded_ff && !opts_ff[flash_opt_pkg::BACKDOOR_KEY_ENABLE_BIT] && !blank_check_erased &&
		secure_state |=> secure_state)
		else $error("unsecured with backdoor key disabled");
	unlock_sticky_a: assert property (
		opts_loaded_ff && !secure_state |=> !secure_state)
		else $error("security re-engaged without reset");
	blank_unlock_a: assert property (
		opts_loaded_ff && blank_check_erased |=> !secure_state)
		else $error("blank check did not unsecure");

	// =========================================
	// scenario covers
	key_unlock_c: cover property (key_hit ##1 !secure_state);
	blank_unlock_c: cover property (blank_check_erased ##1 !secure_state);
	early_cmd_c: cover property (err_set && !ratio_loaded_ff);
	op_complete_c: cover property (op_done);
	ratio_load_c: cover property (ratio_wr && !ratio_loaded_ff);
endmodule // flash_clock_and_security_options

// ---- core/flash_opt_pkg.sv ----
// What this block does
// - ratio bit 7 read-only, 6:0 written once
// - reset clears loaded flag, first write sets
// - erase/program refused until ratio loaded
// - prescale bit picks bus clock or /8
// - flash clock is input over ratio plus one
// - timing pulse is one flash clock tick
// - options copied from nonvolatile byte on first edge after reset
// - key disabled means no key unlock ever
// - matching eight-byte key unlocks until reset
// - key bytes only from secured firmware
// - redirect-off bit disables vector redirection
// - only security code 1:0 is unsecured
// - secure state blocks unsecured memory access
// - key match or blank check forces 1:0
// - key window goes to key or command
// - key compared when key access bit clears
// - early command ignored, access error set
package flash_opt_pkg;
	// =========================================
	// register byte offsets
	localparam logic [7:0] RATIO_OFFS = 8'h00;
	localparam logic [7:0] OPTS_OFFS = 8'h04;
	localparam logic [7:0] CNFG_OFFS = 8'h08;
	localparam logic [7:0] STAT_OFFS = 8'h0c;
	localparam logic [7:0] KEY_BASE = 8'h40;
	localparam logic [7:0] KEY_MASK = 8'he0;
	// =========================================
	// field positions
	localparam int LOADED_BIT = 7;
	localparam int PRE8_BIT = 6;
	localparam int BACKDOOR_KEY_ENABLE_BIT = 7;
	localparam int NORED_BIT = 6;
	localparam int KWA_BIT = 5;
	localparam int BUSY_BIT = 7;
	localparam int RATE_OK_BIT = 6;
	localparam int ERR_BIT = 4;
	localparam int UNSEC_BIT = 1;
	// =========================================
	// reset values and codes
	localparam logic [7:0] OPTS_RESET = 8'hff;
	localparam logic [6:0] RATIO_RESET = 7'h00;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	localparam int KEY_BYTES = 8;
	localparam int PRESCALE_DIV = 8;
	// =========================================
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PULSE_MIN_PS = 5000000;
	localparam int PULSE_MAX_PS = 6700000;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_MAX_CYC = PULSE_MAX_PS / CLK_PERIOD_PS;
endpackage

// ---- core/flash_tick_divider.sv ----
module flash_tick_divider #(
	parameter int DIV_W = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic prescale_by_eight,
	input wire logic [DIV_W-1:0] ratio,
	output logic tick
);
	localparam int PRE_W = $clog2(flash_opt_pkg::PRESCALE_DIV);
	localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(flash_opt_pkg::PRESCALE_DIV - 1);

	logic [PRE_W-1:0] pre_ff;
	logic [DIV_W-1:0] cnt_ff;
	logic pre_en;

	assign pre_en = !prescale_by_eight || (pre_ff == PRE_MAX);
	assign tick = run && pre_en && (cnt_ff == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= '0;
		end else if (!run) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	// reload from ratio gives ratio+1 pre_en cycles per tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else if (!run) begin
			cnt_ff <= ratio;
		end else if (pre_en) begin
			cnt_ff <= (cnt_ff == '0) ? ratio : cnt_ff - 1'b1;
		end
	end
endmodule // flash_tick_divider

// ---- dv/flash_clock_and_security_options_tb_top.sv ----
module flash_clock_and_security_options_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
		$display("BAD %s exp %h got %h", nm, exp, got); end end
	// =========================================
	// stimulus and design
	localparam logic [63:0] key_val = 64'h0123456789abcdef;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [7:0] nonvolatile_options_byte = 8'h83;
	logic fw_secure_source = 1'b1;
	logic access_from_unsecured = 1'b1;
	logic blank_check_erased = 1'b0;
	logic op_start = 1'b0;
	logic [15:0] op_pulse_count = 16'h0;
	logic erase_program_enable, internal_flash_clock, op_busy, op_done, cmd_launch;
	logic [2:0] cmd_addr_idx;
	logic [7:0] cmd_data;
	logic secure_state, mem_access_blocked, vector_redirect_en;
	logic [31:0] rdv;
	logic erv, seen;
	logic [2:0] cidx;
	logic [7:0] cdat;
	int checks = 0;
	int miscompares = 0;
	int cyc = 0;
	always #2.5 pclk = ~pclk;
	flash_clock_and_security_options #(.OPW(16)) i_flash_clock_and_security_options (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nonvolatile_options_byte(nonvolatile_options_byte),
		.stored_backdoor_key(key_val), .fw_secure_source(fw_secure_source),
		.access_from_unsecured(access_from_unsecured), .blank_check_erased(blank_check_erased),
		.op_start(op_start), .op_pulse_count(op_pulse_count),
		.erase_program_enable(erase_program_enable), .internal_flash_clock(internal_flash_clock),
		.op_busy(op_busy), .op_done(op_done), .cmd_launch(cmd_launch),
		.cmd_addr_idx(cmd_addr_idx), .cmd_data(cmd_data), .secure_state(secure_state),
		.mem_access_blocked(mem_access_blocked), .vector_redirect_en(vector_redirect_en));
	// =========================================
	// tasks
	task automatic report_and_stop;
		$display("counts: checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// a hang anywhere ends the run as a failure
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	task automatic do_reset(input logic [7:0] nv);
		@(posedge pclk);
		presetn <= 1'b0;
		nonvolatile_options_byte <= nv;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic watch_cmd;
		seen = 1'b0;
		repeat (4) begin
			@(negedge pclk);
			if (cmd_launch === 1'b1) begin
				seen = 1'b1;
				cidx = cmd_addr_idx;
				cdat = cmd_data;
			end
		end
	endtask
	// spacing between key writes comes from the idle cycle after each transfer
	task automatic key_session(input logic fw);
		@(posedge pclk);
		fw_secure_source <= fw;
		wr(flash_opt_pkg::CNFG_OFFS, 8'h20);
		for (int i = 0; i < 8; i++) wr(flash_opt_pkg::KEY_BASE + 8'(4 * i), key_val[8*i+:8]);
		wr(flash_opt_pkg::CNFG_OFFS, 8'h00);
		fw_secure_source <= 1'b1;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic pulse_op;
		@(posedge pclk);
		op_start <= 1'b1;
		op_pulse_count <= 16'h0002;
		@(posedge pclk);
		op_start <= 1'b0;
	endtask
	// first tick after a load may come early, so measure the second gap
	task automatic tick_gap(output int n);
		int k;
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (internal_flash_clock !== 1'b1 && k < 200);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (internal_flash_clock !== 1'b1 && n < 200);
	endtask
	// =========================================
	// main sequence
	initial begin
		int n, k;
		do_reset(8'h83);
		rd(flash_opt_pkg::RATIO_OFFS);
		`CHK("ratio_rst", 8'h00, rdv[7:0])
		`CHK("ep_en_rst", 1'b0, erase_program_enable)
		rd(flash_opt_pkg::OPTS_OFFS);
		`CHK("opts_load", 8'h83, rdv[7:0])
		`CHK("redir_en", 1'b1, vector_redirect_en)
		`CHK("blocked", 1'b1, mem_access_blocked)
		rd(8'h20);
		`CHK("unmapped_err", 1'b1, erv)
		$display("test reset_defaults done");
		pulse_op();
		repeat (4) @(negedge pclk);
		`CHK("early_op_busy", 1'b0, op_busy)
		wr(flash_opt_pkg::KEY_BASE, 8'h11);
		watch_cmd();
		`CHK("early_cmd", 1'b0, seen)
		rd(flash_opt_pkg::STAT_OFFS);
		`CHK("early_err", 1'b1, rdv[4])
		wr(flash_opt_pkg::STAT_OFFS, 8'h10);
		rd(flash_opt_pkg::STAT_OFFS);
		`CHK("err_clr", 1'b0, rdv[4])
		$display("test early_ops done");
		wr(flash_opt_pkg::RATIO_OFFS, 8'h41);
		rd(flash_opt_pkg::RATIO_OFFS);
		`CHK("ratio_1st", 8'hc1, rdv[7:0])
		wr(flash_opt_pkg::RATIO_OFFS, 8'h05);
		rd(flash_opt_pkg::RATIO_OFFS);
		`CHK("ratio_2nd", 8'hc1, rdv[7:0])
		@(negedge pclk);
		`CHK("ep_en", 1'b1, erase_program_enable)
		tick_gap(n);
		`CHK("tick_period", 16, n)
		rd(flash_opt_pkg::STAT_OFFS);
		`CHK("rate_ok", 1'b0, rdv[6])
		$display("test ratio_and_tick done");
		pulse_op();
		n = 0;
		k = 0;
		seen = 1'b0;
		do begin
			@(negedge pclk);
			k++;
			if (op_busy === 1'b1) n++;
			if (op_done === 1'b1) seen = 1'b1;
		end while (!seen && k < 200);
		`CHK("op_done", 1'b1, seen)
		`CHK("op_len", 1'b1, (n >= 16 && n <= 33))
		wr(flash_opt_pkg::KEY_BASE + 8'h0c, 8'h5a);
		watch_cmd();
		`CHK("cmd_seen", 1'b1, seen)
		`CHK("cmd_idx", 3'h3, cidx)
		`CHK("cmd_data", 8'h5a, cdat)
		$display("test op_and_command done");
		key_session(1'b0);
		`CHK("dbg_key", 1'b1, secure_state)
		key_session(1'b1);
		`CHK("key_unlock", 1'b0, secure_state)
		`CHK("unblocked", 1'b0, mem_access_blocked)
		rd(flash_opt_pkg::STAT_OFFS);
		`CHK("stat_unsec", 1'b1, rdv[1])
		$display("test key_unlock done");
		do_reset(8'h43);
		`CHK("relock", 1'b1, secure_state)
		`CHK("redir_off", 1'b0, vector_redirect_en)
		rd(flash_opt_pkg::RATIO_OFFS);
		`CHK("ratio_rst2", 8'h00, rdv[7:0])
		wr(flash_opt_pkg::RATIO_OFFS, 8'h01);
		tick_gap(n);
		`CHK("tick_plain", 2, n)
		key_session(1'b1);
		`CHK("key_disabled", 1'b1, secure_state)
		@(posedge pclk);
		blank_check_erased <= 1'b1;
		@(posedge pclk);
		blank_check_erased <= 1'b0;
		@(negedge pclk);
		`CHK("blank_unlock", 1'b0, secure_state)
		$display("test key_disabled done");
		for (int i = 0; i < 4; i++) begin
			do_reset({2'b10, 4'h0, 2'(i)});
			`CHK("sec_code", (i != 2), secure_state)
			rd(flash_opt_pkg::OPTS_OFFS);
			`CHK("opts_code", {2'b10, 4'h0, 2'(i)}, rdv[7:0])
		end
		$display("test security_codes done");
		report_and_stop();
	end
endmodule // flash_clock_and_security_options_tb_top
